// ---- bench/prx_host_model.sv ----
// Host bus master model that drives the two-wire link of the sensor.
`timescale 1ns/100ps
module prx_host_model (
   // Clock
   input wire logic sys_clk,
   // Bus
   input wire logic sdaPinOe,
   output logic sclPin,
   output logic sdaWire
);
   logic sdaLow = 1'b0;
   initial sclPin = 1'b1;
   // The data line is open drain with a pull-up.
   assign sdaWire = ~(sdaLow | sdaPinOe);
   // ==========================================
   // Bus conditions
   task automatic tick();
      repeat (15) @(negedge sys_clk);
   endtask
   task automatic startBit();
      tick();
      sdaLow = 1'b0;
      tick();
      sclPin = 1'b1;
      tick();
      sdaLow = 1'b1;
      tick();
      sclPin = 1'b0;
   endtask
   task automatic stopBit();
      tick();
      sdaLow = 1'b1;
      tick();
      sclPin = 1'b1;
      tick();
      sdaLow = 1'b0;
      tick();
   endtask
   // Data changes only while the clock is low, so no false start or stop is seen.
   task automatic xfer(input logic [8:0] dOut, output logic [8:0] dIn);
      for (int i = 8; i >= 0; i--) begin
         tick();
         sdaLow = ~dOut[i];
         tick();
         sclPin = 1'b1;
         tick();
         dIn[i] = sdaWire;
         sclPin = 1'b0;
      end
   endtask
   // ==========================================
   // Transactions
   task automatic txn(input logic [6:0] addr, input logic [7:0] wr[$], input int nRd,
                      output logic [7:0] rd[$], output logic addrAck);
      logic [8:0] got;
      rd = {};
      addrAck = 1'b0;
      if (wr.size() > 0) begin
         startBit();
         xfer({addr, 2'b01}, got);
         addrAck = ~got[0];
         foreach (wr[i]) xfer({wr[i], 1'b1}, got);
      end
      if (nRd > 0) begin
         startBit();
         xfer({addr, 2'b11}, got);
         addrAck = ~got[0];
         for (int i = 0; i < nRd; i++) begin
            xfer({8'hFF, i == nRd - 1}, got);
            rd.push_back(got[8:1]);
         end
      end
      stopBit();
   endtask
endmodule

// ---- bench/test_prx_sensor_ctrl.sv ----
// Self-checking bench for the sensor control front end.
`timescale 1ns/100ps
module test_prx_sensor_ctrl import prx_pkg::*; ();
   localparam int INTEG = 20;
   localparam int WAITN = 30;
   logic sysClk = 1'b0;
   logic linkClk = 1'b0;
   logic rst = 1'b1;
   logic hit = 1'b0;
   logic scl, sda, sdaOe, sdaOut, irq, cStart, cDone, oscOn, asleep, ack;
   logic [7:0] rd[$];
   logic [7:0] none[$];
   logic [7:0] clr[2] = '{8'hE5, 8'hE7};
   int mismatches = 0;
   int checksDone = 0;
   int cycles = 0;
   int d0, d1;
   initial forever #5 sysClk = ~sysClk;
   initial begin
      #3.2;
      forever #7.5 linkClk = ~linkClk;
   end
   prx_sensor_ctrl #(.INTEG_CYCLES(INTEG), .WAIT_CYCLES(WAITN)) dut (.sys_clk(sysClk), .rst(rst),
      .linkClk(linkClk), .sclPin(scl), .sdaPinIn(sda), .sdaPinOut(sdaOut), .sdaPinOe(sdaOe), .proxThreshHit(hit),
      .proxIrq(irq), .convStart(cStart), .convDone(cDone), .oscRunning(oscOn), .sleeping(asleep));
   prx_host_model host (.sys_clk(sysClk), .sdaPinOe(sdaOe), .sclPin(scl), .sdaWire(sda));
   // ==========================================
   // Helpers
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] b[$]);
      host.txn(SLAVE_ADDR, b, 0, rd, ack);
   endtask
   task automatic rdN(input int n);
      host.txn(SLAVE_ADDR, none, n, rd, ack);
   endtask
   // Counts from one event to the next: start to done, or done to start when gap is set.
   // A start in the same cycle as the done gives a gap of zero.
   task automatic span(input logic gap, output int d);
      int t;
      t = 0;
      while ((gap ? cDone : cStart) !== 1'b1 && t < 3000) begin
         @(negedge sysClk);
         t++;
      end
      d = 0;
      if (!gap || cStart !== 1'b1) begin
         do begin
            @(negedge sysClk);
            d++;
         end while ((gap ? cStart : cDone) !== 1'b1 && d < 3000);
      end
      check("span limit", 8'(t == 3000 || d == 3000), 8'h00);
   endtask
   always @(posedge sysClk) begin
      cycles++;
      if (cycles == 90000) begin
         mismatches++;
         stop_test();
      end
   end
   // ==========================================
   // Tests
   initial begin
      repeat (20) @(negedge sysClk);
      rst = 1'b0;
      repeat (30) @(negedge sysClk);
      wr({8'hA0});
      check("own ack", 8'(ack), 8'h01);
      check("sda drive level", 8'(sdaOut), 8'h00);
      rdN(3);
      check("enable reset", rd[0], ENABLE_RESET);
      check("unmapped", rd[1], 8'h00);
      check("prox_integration_time reset", rd[2], PROX_INTEGRATION_TIME_RESET);
      $display("reset test done");
      wr({8'h82, 8'hFE, 8'hFD});
      host.txn(7'h3A, {8'h80}, 0, rd, ack);
      check("foreign ack", 8'(ack), 8'h00);
      wr({8'hE0});
      rdN(2);
      check("repeat 0", rd[0], 8'hFD);
      check("repeat 1", rd[1], 8'hFD);
      wr({8'hA0, 8'h00, 8'h77, 8'hFE});
      wr({8'hA0});
      rdN(3);
      check("auto prox_integration_time", rd[2], 8'hFE);
      $display("pointer test done");
      // command bit set, reserved bits zero
      wr({8'h80, 8'h05});
      span(1'b0, d0);
      hit = 1'b1;
      wr({8'h82, 8'hFF});
      span(1'b0, d1);
      check("unit length", 8'(d0 - d1), 8'(INTEG));
      repeat (5) @(negedge sysClk);
      check("masked irq", 8'(irq), 8'h00);
      wr({8'h80, 8'h0D});
      span(1'b1, d0);
      wr({8'h80, 8'h25});
      span(1'b1, d1);
      check("wait gap", 8'(d0), 8'(WAITN));
      check("no wait gap", 8'(d1), 8'h00);
      span(1'b0, d1);
      repeat (5) @(negedge sysClk);
      check("irq raised", 8'(irq), 8'h01);
      wr({8'h93});
      rdN(1);
      check("status irq", 8'(rd[0][STAT_IRQ_BIT]), 8'h01);
      $display("sequencer test done");
      foreach (clr[i]) begin
         hit = 1'b1;
         span(1'b0, d1);
         hit = 1'b0;
         wr({8'hE0});
         check("nop keeps irq", 8'(irq), 8'h01);
         wr({clr[i]});
         repeat (20) @(negedge sysClk);
         check("irq cleared", 8'(irq), 8'h00);
      end
      hit = 1'b1;
      wr({8'h80, 8'h65});
      repeat (40) @(negedge sysClk);
      check("asleep", 8'(asleep), 8'h01);
      check("osc idle asleep", 8'(oscOn), 8'h00);
      hit = 1'b0;
      wr({8'hE5});
      repeat (20) @(negedge sysClk);
      check("awake", 8'(asleep), 8'h00);
      wr({8'h80, 8'h04});
      repeat (20) @(negedge sysClk);
      check("osc off", 8'(oscOn), 8'h00);
      $display("interrupt test done");
      stop_test();
   end
endmodule

// ---- core/prx_cdc_word.sv ----
// Handshake crossing that carries a configuration word between two clocks.
`timescale 1ns/100ps
module prx_cdc_word #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Source domain
   input wire logic srcClk,
   input wire logic srcRst,
   input wire logic [WIDTH-1:0] srcData,
   // Destination domain
   input wire logic dstClk,
   input wire logic dstRst,
   output logic [WIDTH-1:0] dstData
);
   logic reqT_q;
   logic [WIDTH-1:0] sent_q;
   logic [2:0] ackS_q;
   logic ackF_q;
   logic [2:0] reqS_q;
   logic reqF_q;
   logic reqSeen_q;

   // ==========================================
   // Source side: a new word leaves only once the last one was taken.
   always_ff @(posedge srcClk) begin
      if (srcRst) begin
         ackS_q <= 3'h0;
         ackF_q <= 1'b0;
      end else begin
         ackS_q <= {ackS_q[1:0], reqSeen_q};
         if (ackS_q[1] == ackS_q[2]) begin
            ackF_q <= ackS_q[2];
         end
      end
   end

   always_ff @(posedge srcClk) begin
      if (srcRst) begin
         reqT_q <= 1'b0;
         sent_q <= RESET_VAL;
      end else if (ackF_q == reqT_q && srcData != sent_q) begin
         sent_q <= srcData;
         reqT_q <= ~reqT_q;
      end
   end

   // ==========================================
   // Destination side: the word is stable while the request toggle travels.
   always_ff @(posedge dstClk) begin
      if (dstRst) begin
         reqS_q <= 3'h0;
         reqF_q <= 1'b0;
      end else begin
         reqS_q <= {reqS_q[1:0], reqT_q};
         if (reqS_q[1] == reqS_q[2]) begin
            reqF_q <= reqS_q[2];
         end
      end
   end

   always_ff @(posedge dstClk) begin
      if (dstRst) begin
         reqSeen_q <= 1'b0;
         dstData <= RESET_VAL;
      end else if (reqF_q != reqSeen_q) begin
         reqSeen_q <= reqF_q;
         dstData <= sent_q;
      end
   end
endmodule

// ---- core/prx_sensor_ctrl.sv ----
// Two-wire slave, command and enable registers, and proximity cycle sequencer.
`timescale 1ns/100ps
//
// Contract
// - Answer as slave at address 0x39
// - First written byte is command if bit 7 set, rest data
// - Plain read uses pointer from last command
// - Bits 6:5 select repeat, auto, special
// - Repeat mode keeps pointer fixed
// - Auto mode advances pointer per byte
// - Bits 4:0 load pointer or special code
// - Codes 00101, 00111 clear irq once
// - Sleep after interrupted cycle when enabled
// - Interrupts only while mask bit set
// - Enable bit 3 gates wait timer
// - Enable bit 2 gates proximity cycles
// - Enable bit 0 runs oscillator, timers
// - Integration time in 2.73 ms units
module prx_sensor_ctrl import prx_pkg::*; #(
   parameter int unsigned INTEG_CYCLES = INTEG_UNIT_CYC,
   parameter int unsigned WAIT_CYCLES = WAIT_UNIT_CYC
) (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Two-wire link
   input wire logic linkClk,
   input wire logic sclPin,
   input wire logic sdaPinIn,
   output logic sdaPinOut,
   output logic sdaPinOe,
   // Sensor core
   input wire logic proxThreshHit,
   output logic proxIrq,
   output logic convStart,
   output logic convDone,
   output logic oscRunning,
   output logic sleeping
);
   localparam logic [31:0] UNIT_LAST = 32'(INTEG_CYCLES - 1);
   localparam logic [31:0] WAIT_LAST = 32'(WAIT_CYCLES - 1);
   localparam int P_SDA = 0;
   localparam int P_SCL = 1;
   localparam int P_RST = 2;
   localparam int P_BUSY = 3;
   localparam int P_IRQ = 4;

   typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ADDR_ACK, L_WR, L_WR_ACK, L_RD, L_RD_ACK} prx_link_st_t;
   typedef enum logic [2:0] {S_OFF, S_IDLE, S_INTEG, S_WAIT, S_SLEEP} prx_seq_st_t;

   function automatic logic [7:0] readMux(input logic [4:0] a, input prx_cfg_t c, input logic irq, input logic busy);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         REG_ENABLE: v = c.enable;
         REG_PROX_INTEGRATION_TIME: v = c.prox_integration_time;
         REG_STATUS: begin
            v[STAT_IRQ_BIT] = irq;
            v[STAT_BUSY_BIT] = busy;
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic [8:0] integCount(input logic [7:0] pt);
      return CYCLE_BASE - {1'b0, pt};
   endfunction

   // ==========================================
   // Link input synchronisers
   logic [4:0] pinS1_q, pinS2_q, pinS3_q, pinF_q;
   logic linkRst, sclPrev_q, sdaPrev_q, sclRise, sclFall, startDet, stopDet;
   logic irqQ, busyQ;

   always_ff @(posedge linkClk) begin
      pinS1_q <= {irqQ, busyQ, rst, sclPin, sdaPinIn};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      for (int i = 0; i < 5; i++) begin
         if (pinS2_q[i] == pinS3_q[i]) begin
            pinF_q[i] <= pinS3_q[i];
         end
      end
   end

   assign linkRst = pinF_q[P_RST];

   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else begin
         sclPrev_q <= pinF_q[P_SCL];
         sdaPrev_q <= pinF_q[P_SDA];
      end
   end

   assign sclRise = pinF_q[P_SCL] & ~sclPrev_q;
   assign sclFall = ~pinF_q[P_SCL] & sclPrev_q;
   assign startDet = pinF_q[P_SCL] & sclPrev_q & sdaPrev_q & ~pinF_q[P_SDA];
   assign stopDet = pinF_q[P_SCL] & sclPrev_q & ~sdaPrev_q & pinF_q[P_SDA];

   // ==========================================
   // Link byte engine
   prx_link_st_t lstate_q;
   logic [3:0] bitCnt_q;
   logic [7:0] shReg_q, txReg_q;
   logic isRead_q, firstByte_q, masterAck_q;
   logic [4:0] ptr_q;
   prx_xfer_t xfer_q;
   prx_cfg_t cfg_q, cfgSys;
   logic clrToggle_q;
   logic byteDone, cmdWr, dataWr, specWr, rdDone, rdNext;
   logic [7:0] rdByte;

   assign byteDone = sclFall && lstate_q == L_WR && bitCnt_q == 4'h8;
   assign cmdWr = byteDone && firstByte_q && shReg_q[CMD_SEL_BIT];
   assign dataWr = byteDone && !cmdWr;
   assign specWr = cmdWr && shReg_q[6:5] == XFER_SPECIAL;
   assign rdDone = sclFall && lstate_q == L_RD && bitCnt_q == 4'h8;
   assign rdNext = sclFall && lstate_q == L_RD_ACK && masterAck_q;
   assign rdByte = readMux(ptr_q, cfg_q, pinF_q[P_IRQ], pinF_q[P_BUSY]);

   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         lstate_q <= L_IDLE;
         bitCnt_q <= 4'h0;
         shReg_q <= 8'h00;
         txReg_q <= 8'h00;
         isRead_q <= 1'b0;
         firstByte_q <= 1'b0;
         masterAck_q <= 1'b0;
         sdaPinOe <= 1'b0;
      end else if (stopDet) begin
         lstate_q <= L_IDLE;
         sdaPinOe <= 1'b0;
      end else if (startDet) begin
         lstate_q <= L_ADDR;
         bitCnt_q <= 4'h0;
         firstByte_q <= 1'b1;
         sdaPinOe <= 1'b0;
      end else if (sclRise) begin
         case (lstate_q)
            L_ADDR, L_WR: begin
               shReg_q <= {shReg_q[6:0], pinF_q[P_SDA]};
               bitCnt_q <= bitCnt_q + 4'h1;
            end
            L_RD: bitCnt_q <= bitCnt_q + 4'h1;
            L_RD_ACK: masterAck_q <= ~pinF_q[P_SDA];
            default: ;
         endcase
      end else if (sclFall) begin
         case (lstate_q)
            L_ADDR: begin
               if (bitCnt_q == 4'h8 && shReg_q[7:1] == SLAVE_ADDR) begin
                  lstate_q <= L_ADDR_ACK;
                  isRead_q <= shReg_q[0];
                  sdaPinOe <= 1'b1;
               end else if (bitCnt_q == 4'h8) begin
                  lstate_q <= L_IDLE;
               end
            end
            L_ADDR_ACK: begin
               bitCnt_q <= 4'h0;
               lstate_q <= isRead_q ? L_RD : L_WR;
               txReg_q <= rdByte;
               sdaPinOe <= isRead_q & ~rdByte[7];
            end
            L_WR: begin
               if (bitCnt_q == 4'h8) begin
                  lstate_q <= L_WR_ACK;
                  sdaPinOe <= 1'b1;
               end
            end
            L_WR_ACK: begin
               lstate_q <= L_WR;
               bitCnt_q <= 4'h0;
               firstByte_q <= 1'b0;
               sdaPinOe <= 1'b0;
            end
            L_RD: begin
               if (bitCnt_q == 4'h8) begin
                  lstate_q <= L_RD_ACK;
                  sdaPinOe <= 1'b0;
               end else begin
                  sdaPinOe <= ~txReg_q[3'h7 - bitCnt_q[2:0]];
               end
            end
            L_RD_ACK: begin
               bitCnt_q <= 4'h0;
               lstate_q <= masterAck_q ? L_RD : L_IDLE;
               txReg_q <= rdByte;
               sdaPinOe <= masterAck_q & ~rdByte[7];
            end
            default: lstate_q <= L_IDLE;
         endcase
      end
   end

   always_ff @(posedge linkClk) begin
      sdaPinOut <= 1'b0;
   end

   // ==========================================
   // Command pointer and transfer type
   // held until next non-special command; auto mode steps the pointer per byte
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         ptr_q <= COMMAND_RESET[4:0];
         xfer_q <= prx_xfer_t'(COMMAND_RESET[6:5]);
      end else if (cmdWr && !specWr) begin
         ptr_q <= shReg_q[4:0];
         xfer_q <= prx_xfer_t'(shReg_q[6:5]);
      end else if ((dataWr || rdDone) && xfer_q == XFER_AUTO) begin
         ptr_q <= ptr_q + 5'h1;
      end
   end

   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         clrToggle_q <= 1'b0;
      end else if (specWr && (shReg_q[4:0] == SPF_CLR_A || shReg_q[4:0] == SPF_CLR_B)) begin
         clrToggle_q <= ~clrToggle_q;
      end
   end

   // ==========================================
   // Enable and integration time registers
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         cfg_q.enable <= ENABLE_RESET;
         cfg_q.prox_integration_time <= PROX_INTEGRATION_TIME_RESET;
      end else if (dataWr && ptr_q == REG_ENABLE) begin
         cfg_q.enable <= shReg_q & ENABLE_WMASK;
      end else if (dataWr && ptr_q == REG_PROX_INTEGRATION_TIME) begin
         cfg_q.prox_integration_time <= shReg_q;
      end
   end

   prx_cdc_word #(.WIDTH(16), .RESET_VAL({ENABLE_RESET, PROX_INTEGRATION_TIME_RESET})) cfgCdc (
      .srcClk(linkClk),
      .srcRst(linkRst),
      .srcData(cfg_q),
      .dstClk(sys_clk),
      .dstRst(rst),
      .dstData(cfgSys)
   );

   // ==========================================
   // Clear event into the system clock
   logic [2:0] clrS_q;
   logic clrF_q, clrEvt;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clrS_q <= 3'h0;
         clrF_q <= 1'b0;
      end else begin
         clrS_q <= {clrS_q[1:0], clrToggle_q};
         if (clrS_q[1] == clrS_q[2]) begin
            clrF_q <= clrS_q[2];
         end
      end
   end

   assign clrEvt = clrS_q[1] == clrS_q[2] && clrS_q[2] != clrF_q;

   // ==========================================
   // Proximity cycle sequencer
   prx_seq_st_t state_q;
   logic [31:0] unitCnt_q;
   logic [8:0] cycLeft_q;
   logic endCycle, irqSet;

   assign endCycle = state_q == S_INTEG && unitCnt_q == UNIT_LAST && cycLeft_q == 9'h001;
   assign irqSet = endCycle && proxThreshHit && cfgSys.enable[EN_MASK_BIT];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqQ <= 1'b0;
      end else if (irqSet) begin
         irqQ <= 1'b1;
      end else if (clrEvt) begin
         irqQ <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= S_OFF;
         unitCnt_q <= 32'h0;
         cycLeft_q <= 9'h000;
         convStart <= 1'b0;
         convDone <= 1'b0;
      end else begin
         convStart <= 1'b0;
         convDone <= 1'b0;
         if (!cfgSys.enable[EN_OSC_BIT]) begin
            state_q <= S_OFF;
            unitCnt_q <= 32'h0;
         end else begin
            case (state_q)
               S_OFF: state_q <= S_IDLE;
               S_IDLE: begin
                  if (cfgSys.enable[EN_PROX_BIT]) begin
                     state_q <= S_INTEG;
                     unitCnt_q <= 32'h0;
                     cycLeft_q <= integCount(cfgSys.prox_integration_time);
                     convStart <= 1'b1;
                  end
               end
               S_INTEG: begin
                  if (!cfgSys.enable[EN_PROX_BIT]) begin
                     state_q <= S_IDLE;
                  end else if (unitCnt_q != UNIT_LAST) begin
                     unitCnt_q <= unitCnt_q + 32'h1;
                  end else if (cycLeft_q != 9'h001) begin
                     unitCnt_q <= 32'h0;
                     cycLeft_q <= cycLeft_q - 9'h001;
                  end else begin
                     unitCnt_q <= 32'h0;
                     convDone <= 1'b1;
                     if (cfgSys.enable[EN_SAI_BIT] && (irqQ || irqSet)) begin
                        state_q <= S_SLEEP;
                     end else if (cfgSys.enable[EN_WAIT_BIT]) begin
                        state_q <= S_WAIT;
                     end else begin
                        cycLeft_q <= integCount(cfgSys.prox_integration_time);
                        convStart <= 1'b1;
                     end
                  end
               end
               S_WAIT: begin
                  if (!cfgSys.enable[EN_PROX_BIT]) begin
                     state_q <= S_IDLE;
                  end else if (unitCnt_q != WAIT_LAST) begin
                     unitCnt_q <= unitCnt_q + 32'h1;
                  end else begin
                     state_q <= S_INTEG;
                     unitCnt_q <= 32'h0;
                     cycLeft_q <= integCount(cfgSys.prox_integration_time);
                     convStart <= 1'b1;
                  end
               end
               S_SLEEP: begin
                  if (!irqQ) begin
                     state_q <= S_IDLE;
                  end
               end
               default: state_q <= S_OFF;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busyQ <= 1'b0;
         proxIrq <= 1'b0;
         oscRunning <= 1'b0;
         sleeping <= 1'b0;
      end else begin
         busyQ <= state_q == S_INTEG || state_q == S_WAIT;
         proxIrq <= irqQ;
         oscRunning <= state_q != S_OFF && state_q != S_SLEEP;
         sleeping <= state_q == S_SLEEP;
      end
   end

   // ==========================================
   // Assertions
   addr_ack_a: assert property (@(posedge linkClk) disable iff (linkRst)
      lstate_q == L_ADDR_ACK |-> sdaPinOe && $past(shReg_q[7:1]) == SLAVE_ADDR)
      else $error("Address acknowledged for a foreign address.");
   cmd_first_a: assert property (@(posedge linkClk) disable iff (linkRst)
      byteDone && !firstByte_q && ptr_q == REG_ENABLE |=> cfg_q.enable == ($past(shReg_q) & ENABLE_WMASK))
      else $error("Later byte not taken as data.");
   ptr_repeat_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (dataWr || rdDone) && xfer_q == XFER_REPEAT |=> $stable(ptr_q))
      else $error("Pointer moved in repeat mode.");
   ptr_inc_a: assert property (@(posedge linkClk) disable iff (linkRst)
      (dataWr || rdDone) && xfer_q == XFER_AUTO |=> ptr_q == $past(ptr_q) + 5'h1)
      else $error("Pointer did not advance in auto mode.");
   ptr_hold_a: assert property (@(posedge linkClk) disable iff (linkRst)
      startDet || specWr |=> $stable(ptr_q) && $stable(xfer_q))
      else $error("Pointer lost outside a command.");
   irq_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
      clrEvt && !irqSet |=> !irqQ ##1 !proxIrq)
      else $error("Interrupt clear did not take effect.");
   irq_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(irqQ) |-> $past(cfgSys.enable[EN_MASK_BIT]) && $past(endCycle))
      else $error("Interrupt raised while masked.");
   sleep_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
      endCycle && cfgSys.enable[EN_OSC_BIT] && cfgSys.enable[EN_PROX_BIT] && cfgSys.enable[EN_SAI_BIT]
      && (irqQ || irqSet) |=> state_q == S_SLEEP ##1 sleeping)
      else $error("No sleep after interrupted cycle.");
   wait_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      $changed(state_q) && state_q == S_WAIT |-> $past(cfgSys.enable[EN_WAIT_BIT]))
      else $error("Wait entered while disabled.");
   prox_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      !cfgSys.enable[EN_PROX_BIT] |=> state_q != S_INTEG && !convStart)
      else $error("Cycle ran while proximity disabled.");
   osc_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      !cfgSys.enable[EN_OSC_BIT] |=> state_q == S_OFF ##1 !oscRunning)
      else $error("Timers ran with oscillator off.");
   integ_len_a: assert property (@(posedge sys_clk) disable iff (rst)
      convStart |-> cycLeft_q == CYCLE_BASE - {1'b0, $past(cfgSys.prox_integration_time)})
      else $error("Integration count differs from 256 minus setting.");
   seq_wait_c: cover property (@(posedge sys_clk) disable iff (rst) convDone ##1 state_q == S_WAIT);
   seq_sleep_c: cover property (@(posedge sys_clk) disable iff (rst) sleeping ##[1:1000] !sleeping);
   irq_clr_c: cover property (@(posedge sys_clk) disable iff (rst) irqQ ##1 clrEvt);
   auto_read_c: cover property (@(posedge linkClk) disable iff (linkRst) rdNext && xfer_q == XFER_AUTO);
endmodule

// ---- include/prx_pkg.sv ----
// Shared constants and types of the proximity sensor control front end.
package prx_pkg;
   // ==========================================
   // Bus address and register map
   localparam logic [6:0] SLAVE_ADDR = 7'h39;
   localparam logic [4:0] REG_ENABLE = 5'h00;
   localparam logic [4:0] REG_PROX_INTEGRATION_TIME = 5'h02;
   localparam logic [4:0] REG_STATUS = 5'h13;
   // ==========================================
   // Reset values
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] PROX_INTEGRATION_TIME_RESET = 8'hFF;
   localparam logic [7:0] COMMAND_RESET = 8'h00;
   // ==========================================
   // Field positions
   localparam int CMD_SEL_BIT = 7;
   localparam int EN_OSC_BIT = 0;
   localparam int EN_PROX_BIT = 2;
   localparam int EN_WAIT_BIT = 3;
   localparam int EN_MASK_BIT = 5;
   localparam int EN_SAI_BIT = 6;
   localparam logic [7:0] ENABLE_WMASK = 8'h6D;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_IRQ_BIT = 5;
   // ==========================================
   // Command transfer types and special codes
   typedef enum logic [1:0] {
      XFER_REPEAT = 2'h0,
      XFER_AUTO = 2'h1,
      XFER_RSVD = 2'h2,
      XFER_SPECIAL = 2'h3
   } prx_xfer_t;
   localparam logic [4:0] SPF_NOP = 5'h00;
   localparam logic [4:0] SPF_CLR_A = 5'h05;
   localparam logic [4:0] SPF_CLR_B = 5'h07;
   // ==========================================
   // Timing
   localparam real SYS_CLK_MHZ = 100.0;
   localparam real INTEG_UNIT_MS = 2.73;
   localparam int INTEG_UNIT_CYC = $rtoi(INTEG_UNIT_MS * 1000.0 * SYS_CLK_MHZ + 0.5);
   localparam int WAIT_UNIT_CYC = INTEG_UNIT_CYC;
   localparam logic [8:0] CYCLE_BASE = 9'h100;
   // ==========================================
   // Carriers
   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] prox_integration_time;
   } prx_cfg_t;
endpackage
